// File: rtl/rcl_top.sv
// Ramp comparators, deviation, accumulator limits and ramp counter.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rcl_top #(
	parameter int ADDR_W = 12,
	parameter int RAMPS = 8
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Ramp sequencer side
	input wire logic [2:0] ramp_index_in,
	input wire logic ramp_transition_in,
	input wire logic ramp_tick_in,
	input wire logic signed [32:0] ramp_increment_in,
	input wire logic accum_clear_in,
	input wire logic trig_a_in,
	input wire logic trig_b_in,
	input wire logic trig_c_in,
	// Results
	output logic ramp_enable_out,
	output logic ramp_start_out,
	output logic counter_terminal_out,
	output logic signed [32:0] accum_out,
	output logic signed [32:0] deviated_out,
	output logic cmp_a_level_out,
	output logic cmp_b_level_out,
	output logic [3:0] cmp_a_src_code_out,
	output logic [3:0] cmp_b_src_code_out
);
	import rcl_pkg::*;
	default clocking asrt_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	if (RAMPS != 8 || ADDR_W < 10) begin : param_check
		$error("rcl_top: unsupported parameters");
	end

	// ==========================================================
	// Register storage
	logic [7:0] cfg_r [CFG_FIRST:CFG_LAST];
	logic [7:0] div_low_r;
	logic [1:0] dev_sel_r;
	logic ramp_en_r;
	logic ramp_en_prev_r;
	logic [12:0] count_r;
	logic signed [32:0] accum_r;
	logic signed [32:0] deviated_r;
	logic cmp_a_r;
	logic cmp_b_r;
	logic start_r;
	logic terminal_r;
	logic trig_a_prev_r;
	logic trig_b_prev_r;
	logic trig_c_prev_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// Assembles a 33-bit signed value from a sign bit and four bytes.
	function automatic logic signed [32:0] wide33(input logic sgn,
			input int base);
		wide33 = {sgn, cfg_r[base+3], cfg_r[base+2], cfg_r[base+1],
			cfg_r[base]};
	endfunction

	// Picks a trigger level by a two-bit selector.
	function automatic logic pick_trig(input logic [1:0] sel,
			input logic lvl0, input logic a, input logic b, input logic c);
		case (sel)
			RCL_SEL_ALWAYS: pick_trig = lvl0;
			RCL_SEL_TRIG_A: pick_trig = a;
			RCL_SEL_TRIG_B: pick_trig = b;
			default: pick_trig = c;
		endcase
	endfunction

	logic [7:0] sign_bits;
	logic signed [32:0] cmp_a_thr;
	logic signed [32:0] cmp_b_thr;
	logic signed [32:0] dev_val;
	logic signed [32:0] lim_low;
	logic signed [32:0] lim_high;
	logic [12:0] count_top;
	logic count_auto;
	logic [1:0] count_sel;

	assign sign_bits = cfg_r[IDX_SIGN_BITS];
	assign cmp_a_thr = wide33(sign_bits[SIGN_CMP_A], IDX_CMP_A_LOW);
	assign cmp_b_thr = wide33(sign_bits[SIGN_CMP_B], IDX_CMP_B_LOW);
	assign dev_val = wide33(sign_bits[SIGN_DEV], IDX_DEV_LOW);
	assign lim_low = wide33(sign_bits[SIGN_LIM_LOW], IDX_LIM_LOW_LOW);
	assign lim_high = wide33(sign_bits[SIGN_LIM_HIGH], IDX_LIM_HIGH_LOW);
	assign count_top = {cfg_r[IDX_COUNT_CTRL][COUNT_TOP_MSB:0],
		cfg_r[IDX_COUNT_LOW]};
	assign count_auto = cfg_r[IDX_COUNT_CTRL][COUNT_AUTO_BIT];
	assign count_sel = cfg_r[IDX_COUNT_CTRL][COUNT_SEL_LSB+1:COUNT_SEL_LSB];

	// ==========================================================
	// APB decode
	logic [7:0] idx;
	logic setup_ph;
	logic wr_en;
	logic idx_in_cfg;
	logic mapped;

	assign idx = paddr_in[9:2];
	assign setup_ph = psel_in && !penable_in;
	assign wr_en = psel_in && penable_in && pwrite_in && !pslverr_r;
	assign idx_in_cfg = (32'(idx) >= CFG_FIRST) && (32'(idx) <= CFG_LAST);
	assign mapped = (paddr_in[1:0] == 2'h0) &&
		(paddr_in[ADDR_W-1:10] == '0) &&
		(idx_in_cfg || idx == IDX_DIV_LOW || idx == IDX_RAMP_CTRL ||
		idx == IDX_DEV_SELECT || idx == IDX_STATUS ||
		idx == IDX_COUNT_VAL_LOW || idx == IDX_COUNT_VAL_HIGH);

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (idx_in_cfg) begin
			rd_mux = {24'h0, cfg_r[idx]};
		end else begin
			case (idx)
				IDX_DIV_LOW: rd_mux = {24'h0, div_low_r};
				IDX_RAMP_CTRL: rd_mux = {31'h0, ramp_en_r};
				IDX_DEV_SELECT: rd_mux = {30'h0, dev_sel_r};
				IDX_STATUS: rd_mux = {28'h0, deviated_r != accum_r,
					cmp_b_r, cmp_a_r, ramp_en_r};
				IDX_COUNT_VAL_LOW: rd_mux = {24'h0, count_r[7:0]};
				IDX_COUNT_VAL_HIGH: rd_mux = {27'h0, count_r[12:8]};
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// Read data and error are captured in setup; access completes at once.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r <= mapped ? rd_mux : 32'h0;
			pslverr_r <= !mapped;
		end
	end

	assign prdata_out = prdata_r;
	assign pslverr_out = pslverr_r && psel_in && penable_in;
	assign pready_out = 1'b1;

	// Configuration bytes; the high limit comes out of reset at its maximum.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			for (int i = CFG_FIRST; i <= CFG_LAST; i++) begin
				cfg_r[i] <= (i >= IDX_LIM_HIGH_LOW && i < IDX_COUNT_LOW) ?
					RST_LIM_HIGH_BYTE : RST_BYTE;
			end
		end else if (wr_en && idx_in_cfg) begin
			cfg_r[idx] <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			div_low_r <= RST_BYTE;
			dev_sel_r <= RCL_SEL_ALWAYS;
		end else if (wr_en) begin
			if (idx == IDX_DIV_LOW) begin
				div_low_r <= pwdata_in[7:0];
			end
			if (idx == IDX_DEV_SELECT) begin
				dev_sel_r <= pwdata_in[1:0];
			end
		end
	end

	// ==========================================================
	// Ramp enable and ramp counter
	logic trig_a_rise;
	logic trig_b_rise;
	logic trig_c_rise;
	logic count_event;
	logic count_hit;
	logic en_write;

	assign trig_a_rise = trig_a_in && !trig_a_prev_r;
	assign trig_b_rise = trig_b_in && !trig_b_prev_r;
	assign trig_c_rise = trig_c_in && !trig_c_prev_r;
	assign count_event = ramp_en_r && pick_trig(count_sel,
		ramp_transition_in, trig_a_rise, trig_b_rise, trig_c_rise);
	assign count_hit = count_event && (count_top != 13'h0) &&
		(count_r + 13'h1 == count_top);
	assign en_write = wr_en && idx == IDX_RAMP_CTRL;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			trig_a_prev_r <= 1'b0;
			trig_b_prev_r <= 1'b0;
			trig_c_prev_r <= 1'b0;
			ramp_en_prev_r <= 1'b0;
		end else begin
			trig_a_prev_r <= trig_a_in;
			trig_b_prev_r <= trig_b_in;
			trig_c_prev_r <= trig_c_in;
			ramp_en_prev_r <= ramp_en_r;
		end
	end

	// A software write in the same cycle wins over the automatic clear.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ramp_en_r <= 1'b0;
		end else if (en_write) begin
			ramp_en_r <= pwdata_in[RAMP_EN_BIT];
		end else if (count_hit && count_auto) begin
			ramp_en_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			count_r <= 13'h0;
			terminal_r <= 1'b0;
		end else begin
			terminal_r <= count_hit;
			if (ramp_en_r && !ramp_en_prev_r) begin
				count_r <= 13'h0;
			end else if (count_hit) begin
				count_r <= 13'h0;
			end else if (count_event && count_top != 13'h0) begin
				count_r <= count_r + 13'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			start_r <= 1'b0;
		end else begin
			start_r <= wr_en && idx == IDX_DIV_LOW && ramp_en_r;
		end
	end

	// ==========================================================
	// Accumulator with saturating limits, then deviation
	logic signed [33:0] sum_wide;
	logic signed [32:0] sum_limited;
	logic dev_active;

	assign sum_wide = 34'(accum_r) + 34'(ramp_increment_in);
	always_comb begin
		sum_limited = sum_wide[32:0];
		if (sum_wide > 34'(lim_high)) begin
			sum_limited = lim_high;
		end else if (sum_wide < 34'(lim_low)) begin
			sum_limited = lim_low;
		end
	end

	assign dev_active = pick_trig(dev_sel_r, 1'b1, trig_a_in, trig_b_in,
		trig_c_in);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			accum_r <= 33'h0;
		end else if (accum_clear_in) begin
			accum_r <= 33'h0;
		end else if (ramp_tick_in) begin
			accum_r <= sum_limited;
		end
	end

	// The offset is added after limiting, so this output may pass the limits.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			deviated_r <= 33'h0;
		end else begin
			deviated_r <= dev_active ? accum_r + dev_val : accum_r;
		end
	end

	// ==========================================================
	// Comparators
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cmp_a_r <= 1'b0;
			cmp_b_r <= 1'b0;
		end else begin
			cmp_a_r <= cfg_r[IDX_CMP_A_MASK][ramp_index_in] &&
				(accum_r >= cmp_a_thr);
			cmp_b_r <= cfg_r[IDX_CMP_B_MASK][ramp_index_in] &&
				(accum_r >= cmp_b_thr);
		end
	end

	assign ramp_enable_out = ramp_en_r;
	assign ramp_start_out = start_r;
	assign counter_terminal_out = terminal_r;
	assign accum_out = accum_r;
	assign deviated_out = deviated_r;
	assign cmp_a_level_out = cmp_a_r;
	assign cmp_b_level_out = cmp_b_r;
	assign cmp_a_src_code_out = TRIG_SRC_CMP_A;
	assign cmp_b_src_code_out = TRIG_SRC_CMP_B;

	// ==========================================================
	// Assertions
	cmp_a_mask_a: assert property (
		!$past(cfg_r[IDX_CMP_A_MASK][ramp_index_in]) |-> !cmp_a_r)
		else $error("compare A fired on a masked ramp");
	cmp_b_mask_a: assert property (
		!$past(cfg_r[IDX_CMP_B_MASK][ramp_index_in]) |-> !cmp_b_r)
		else $error("compare B fired on a masked ramp");
	cmp_a_detect_a: assert property (
		cfg_r[IDX_CMP_A_MASK][ramp_index_in] && accum_r >= cmp_a_thr
		|=> cmp_a_r) else $error("compare A missed a detection");
	accum_low_a: assert property (
		ramp_tick_in && !accum_clear_in && lim_low <= lim_high |=>
		accum_r >= $past(lim_low)) else $error("accumulator below low limit");
	accum_high_a: assert property (
		ramp_tick_in && !accum_clear_in && lim_low <= lim_high |=>
		accum_r <= $past(lim_high)) else $error("accumulator over high limit");
	dev_apply_a: assert property (
		dev_sel_r == RCL_SEL_ALWAYS |=> deviated_r == $past(accum_r + dev_val))
		else $error("deviation not applied");
	count_zero_a: assert property (
		count_top == '0 && ramp_en_prev_r |=> !terminal_r && $stable(count_r))
		else $error("disabled counter moved");
	count_restart_a: assert property (
		$rose(ramp_en_r) |=> count_r == 13'h0)
		else $error("counter not reset on enable rise");
	auto_clear_a: assert property (
		count_hit && count_auto && !en_write |=> !ramp_en_r && terminal_r)
		else $error("ramp enable not cleared at terminal count");
	start_pulse_a: assert property (
		wr_en && idx == IDX_DIV_LOW && ramp_en_r |=> ramp_start_out ##1
		(!ramp_start_out || $past(wr_en))) else $error("start pulse wrong");
endmodule
`default_nettype wire

// File: rtl/rcl_pkg.sv
// Package with register indices, field positions and reset values.
package rcl_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_DIV_LOW = 8'h10;
	localparam logic [7:0] IDX_RAMP_CTRL = 8'h3a;
	localparam logic [7:0] IDX_CMP_A_LOW = 8'h3c;
	localparam logic [7:0] IDX_CMP_A_MASK = 8'h40;
	localparam logic [7:0] IDX_CMP_B_LOW = 8'h41;
	localparam logic [7:0] IDX_CMP_B_MASK = 8'h45;
	localparam logic [7:0] IDX_SIGN_BITS = 8'h46;
	localparam logic [7:0] IDX_DEV_LOW = 8'h47;
	localparam logic [7:0] IDX_LIM_LOW_LOW = 8'h4b;
	localparam logic [7:0] IDX_LIM_HIGH_LOW = 8'h4f;
	localparam logic [7:0] IDX_COUNT_LOW = 8'h53;
	localparam logic [7:0] IDX_COUNT_CTRL = 8'h54;
	localparam logic [7:0] IDX_DEV_SELECT = 8'h56;
	localparam logic [7:0] IDX_STATUS = 8'h57;
	localparam logic [7:0] IDX_COUNT_VAL_LOW = 8'h58;
	localparam logic [7:0] IDX_COUNT_VAL_HIGH = 8'h59;
	localparam int CFG_FIRST = 8'h3c;
	localparam int CFG_LAST = 8'h54;
	// ==========================================================
	// Field positions
	localparam int SIGN_CMP_A = 0;
	localparam int SIGN_CMP_B = 1;
	localparam int SIGN_DEV = 2;
	localparam int SIGN_LIM_LOW = 3;
	localparam int SIGN_LIM_HIGH = 4;
	localparam int RAMP_EN_BIT = 0;
	localparam int COUNT_AUTO_BIT = 5;
	localparam int COUNT_SEL_LSB = 6;
	localparam int COUNT_TOP_MSB = 4;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_LIM_HIGH_BYTE = 8'hff;
	// ==========================================================
	// Trigger source codes of the comparator levels
	localparam logic [3:0] TRIG_SRC_CMP_A = 4'h5;
	localparam logic [3:0] TRIG_SRC_CMP_B = 4'hd;
	// ==========================================================
	// Selector encodings
	typedef enum logic [1:0] {
		RCL_SEL_ALWAYS = 2'h0,
		RCL_SEL_TRIG_A = 2'h1,
		RCL_SEL_TRIG_B = 2'h2,
		RCL_SEL_TRIG_C = 2'h3
	} rcl_sel_t;
endpackage

// File: tb/test_ramp_compare_limit_counter.sv
// Self-checking bench of the ramp comparator, limit and counter block.
`timescale 1ns/1ps
`default_nettype none
module test_ramp_compare_limit_counter;
	import rcl_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0;
	logic [2:0] ramp_index_in = 3'h0;
	logic ramp_transition_in = 1'b0;
	logic ramp_tick_in = 1'b0;
	logic signed [32:0] ramp_increment_in = 33'h0;
	logic accum_clear_in = 1'b0;
	logic trig_a_in = 1'b0;
	logic trig_b_in = 1'b0;
	logic trig_c_in = 1'b0;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, ramp_enable_out, ramp_start_out;
	logic counter_terminal_out, cmp_a_level_out, cmp_b_level_out;
	logic signed [32:0] accum_out, deviated_out;
	logic [3:0] cmp_a_src_code_out, cmp_b_src_code_out;
	// ==========================================================
	// Reference model state
	int fail_count = 0;
	int checked = 0;
	int hits;
	logic [31:0] rd_v;
	logic err_v;
	logic [7:0] sign_sh = 8'h00;
	logic [7:0] mask_a, mask_b;
	logic act;
	longint acc_m = 0, lo_m = 0, hi_m = 64'hffffffff, dev_m = 0;
	longint tha = -100, thb = 300;

	rcl_top dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.ramp_index_in(ramp_index_in),
		.ramp_transition_in(ramp_transition_in),
		.ramp_tick_in(ramp_tick_in), .ramp_increment_in(ramp_increment_in),
		.accum_clear_in(accum_clear_in), .trig_a_in(trig_a_in),
		.trig_b_in(trig_b_in), .trig_c_in(trig_c_in),
		.ramp_enable_out(ramp_enable_out), .ramp_start_out(ramp_start_out),
		.counter_terminal_out(counter_terminal_out), .accum_out(accum_out),
		.deviated_out(deviated_out), .cmp_a_level_out(cmp_a_level_out),
		.cmp_b_level_out(cmp_b_level_out),
		.cmp_a_src_code_out(cmp_a_src_code_out),
		.cmp_b_src_code_out(cmp_b_src_code_out));

	always #5 sys_clk_in = ~sys_clk_in;
	// ==========================================================
	// Bus, stimulus and compare tasks
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= {2'b00, idx, 2'b00};
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		@(posedge sys_clk_in);
		while (pready_out !== 1'b1) begin
			@(posedge sys_clk_in);
		end
		rd_v = prdata_out;
		err_v = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk_word(rd_v, exp);
	endtask
	task automatic wr33(input logic [7:0] base, input int sb,
		input logic [32:0] v);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, base + 8'(i), {24'h0, v[8*i +: 8]});
		end
		sign_sh[sb] = v[32];
		apb(1'b1, IDX_SIGN_BITS, {24'h0, sign_sh});
	endtask
	task automatic step(input logic clr, input longint inc);
		longint s;
		@(posedge sys_clk_in);
		accum_clear_in <= clr;
		ramp_tick_in <= ~clr;
		ramp_increment_in <= 33'(inc);
		@(posedge sys_clk_in);
		accum_clear_in <= 1'b0;
		ramp_tick_in <= 1'b0;
		s = acc_m + inc;
		if (clr) acc_m = 0;
		else if (s > hi_m) acc_m = hi_m;
		else if (s < lo_m) acc_m = lo_m;
		else acc_m = s;
		repeat (3) @(posedge sys_clk_in);
		chk_val(accum_out, 33'(acc_m));
	endtask
	task automatic pulse_ev(input int sel);
		@(posedge sys_clk_in);
		ramp_transition_in <= (sel == 0);
		trig_a_in <= (sel == 1);
		trig_b_in <= (sel == 2);
		trig_c_in <= (sel == 3);
		@(posedge sys_clk_in);
		ramp_transition_in <= 1'b0;
		trig_a_in <= 1'b0;
		trig_b_in <= 1'b0;
		trig_c_in <= 1'b0;
	endtask
	task automatic watch(input int which);
		hits = 0;
		repeat (6) begin
			@(posedge sys_clk_in);
			if ((which == 0 ? counter_terminal_out : ramp_start_out) === 1'b1)
				hits++;
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#500000;
		fail_count++;
		complete_run();
	end
	// ==========================================================
	// Test sequence
	initial begin
		void'($urandom(32'hef9da4ca));
		repeat (20) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		rdchk(IDX_CMP_A_MASK, 32'h0);
		rdchk(IDX_CMP_B_MASK, 32'h0);
		rdchk(IDX_COUNT_CTRL, 32'h0);
		rdchk(8'h55, 32'h0);
		chk_word({31'h0, err_v}, 32'h1);
		step(1'b0, -5);
		$display("test reset done");
		// Comparators over every ramp index with saturating accumulator.
		lo_m = -1000;
		hi_m = 1000;
		wr33(IDX_LIM_LOW_LOW, SIGN_LIM_LOW, 33'(lo_m));
		wr33(IDX_LIM_HIGH_LOW, SIGN_LIM_HIGH, 33'(hi_m));
		wr33(IDX_CMP_A_LOW, SIGN_CMP_A, 33'(tha));
		wr33(IDX_CMP_B_LOW, SIGN_CMP_B, 33'(thb));
		rdchk(IDX_SIGN_BITS, {24'h0, sign_sh});
		mask_a = 8'($urandom());
		mask_b = 8'($urandom());
		apb(1'b1, IDX_CMP_A_MASK, {24'h0, mask_a});
		apb(1'b1, IDX_CMP_B_MASK, {24'h0, mask_b});
		rdchk(IDX_CMP_A_MASK, {24'h0, mask_a});
		rdchk(IDX_CMP_B_MASK, {24'h0, mask_b});
		for (int k = 0; k < 8; k++) begin
			step(1'b0, longint'($urandom_range(3000)) - 1500);
			for (int i = 0; i < 8; i++) begin
				ramp_index_in <= 3'(i);
				repeat (3) @(posedge sys_clk_in);
				act = mask_a[i] && acc_m >= tha;
				chk_val(33'(cmp_a_level_out), 33'(act));
				act = mask_b[i] && acc_m >= thb;
				chk_val(33'(cmp_b_level_out), 33'(act));
			end
		end
		chk_val(33'({cmp_b_src_code_out, cmp_a_src_code_out}), 33'h0d5);
		$display("test comparators done");
		// Deviation with each selector, positive then negative.
		step(1'b0, 5000);
		for (int d = 0; d < 2; d++) begin
			dev_m = (d == 0) ? 300 + longint'($urandom_range(500)) : -777;
			wr33(IDX_DEV_LOW, SIGN_DEV, 33'(dev_m));
			for (int s = 0; s < 4; s++) begin
				apb(1'b1, IDX_DEV_SELECT, 32'(s));
				for (int r = 0; r < 3; r++) begin
					{trig_a_in, trig_b_in, trig_c_in} <= 3'($urandom());
					repeat (3) @(posedge sys_clk_in);
					act = (s == 0) || (s == 1 && trig_a_in) ||
						(s == 2 && trig_b_in) || (s == 3 && trig_c_in);
					chk_val(deviated_out, 33'(acc_m + (act ? dev_m : 0)));
				end
			end
		end
		wr33(IDX_DEV_LOW, SIGN_DEV, 33'h0);
		{trig_a_in, trig_b_in, trig_c_in} <= 3'h0;
		step(1'b1, 123);
		$display("test deviation done");
		// Ramp counter with each advance source and both auto modes.
		apb(1'b1, IDX_COUNT_LOW, 32'h2);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, IDX_COUNT_CTRL, {24'h0, 2'(s), ~s[0], 5'h0});
			apb(1'b1, IDX_RAMP_CTRL, 32'h0);
			apb(1'b1, IDX_RAMP_CTRL, 32'h1);
			pulse_ev(s);
			watch(0);
			chk_word(32'(hits), 32'h0);
			rdchk(IDX_COUNT_VAL_LOW, 32'h1);
			apb(1'b1, IDX_RAMP_CTRL, 32'h0);
			apb(1'b1, IDX_RAMP_CTRL, 32'h1);
			pulse_ev(s);
			watch(0);
			chk_word(32'(hits), 32'h0);
			rdchk(IDX_COUNT_VAL_LOW, 32'h1);
			pulse_ev(s);
			watch(0);
			chk_word(32'(hits), 32'h1);
			chk_word(32'(ramp_enable_out), 32'(s[0]));
		end
		apb(1'b1, IDX_COUNT_LOW, 32'h0);
		apb(1'b1, IDX_COUNT_CTRL, 32'h20);
		apb(1'b1, IDX_RAMP_CTRL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			pulse_ev(0);
		end
		watch(0);
		chk_word(32'(hits), 32'h0);
		chk_word(32'(ramp_enable_out), 32'h1);
		rdchk(IDX_STATUS, {28'h0, 1'b0, mask_b[7] && acc_m >= thb,
			mask_a[7] && acc_m >= tha, 1'b1});
		$display("test counter done");
		// Ramp start on the divider low byte write.
		apb(1'b1, IDX_DIV_LOW, 32'h5a);
		watch(1);
		chk_word(32'(hits), 32'h1);
		apb(1'b1, IDX_RAMP_CTRL, 32'h0);
		apb(1'b1, IDX_DIV_LOW, 32'h5a);
		watch(1);
		chk_word(32'(hits), 32'h0);
		$display("test ramp start done");
		complete_run();
	end
endmodule
`default_nettype wire
